/* rtccr_ctrl.v */
// clock control and status register block with a classic wishbone slave
`timescale 1ns/100ps
`include "rtccr_map.vh"

module rtccr_ctrl (
  input  wire        clk_i,
  input  wire        rst_i,
  input  wire        sys_reset_i,
  input  wire        cyc_i,
  input  wire        stb_i,
  input  wire        we_i,
  input  wire [3:0]  adr_i,
  input  wire [3:0]  sel_i,
  input  wire [31:0] dat_i,
  output reg  [31:0] dat_o,
  output reg         ack_o,
  input  wire        cpu_idle_i,
  input  wire        minute_tick_i,
  input  wire        rtc_tick_i,
  input  wire        half_second_tick_i,
  input  wire        seconds_clk_i,
  input  wire        alarm_pulse_i,
  input  wire        clk_src_running_i,
  input  wire        time_busy_i,
  output reg         module_enable_o,
  output reg         bus_clk_enable_o,
  output reg         cal_add_pulse_o,
  output reg         cal_remove_pulse_o,
  output reg         seconds_write_o,
  output reg  [6:0]  seconds_value_o,
  output reg         rtc_pin_o,
  output reg         rtc_pin_oe_o
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  reg  [9:0]  cal_r;
  reg         on_r;
  reg         stop_in_idle_r;
  reg         pin_source_select_r;
  reg         write_unlock_r;
  reg         pin_output_enable_r;
  reg         half_second_status_r;
  reg  [6:0]  seconds_r;
  reg  [1:0]  unlock_state_r;
  reg  [9:0]  cal_count_r;
  reg         cal_neg_r;
  reg  [3:0]  meta_r;
  reg  [3:0]  sync_r;

  localparam [1:0] UNL_IDLE  = 2'b00;
  localparam [1:0] UNL_KEY1  = 2'b01;
  localparam [1:0] UNL_ARMED = 2'b10;

  wire        wr_req;
  wire        rd_req;
  wire        hit_ctrl;
  wire        hit_time;
  wire        hit_unlock;
  wire [31:0] ctrl_rd;
  wire [31:0] wmask;
  wire [31:0] ctrl_wr;
  wire        sec_wr;
  wire        seconds_clk_s;
  wire        alarm_s;
  wire        clk_running_s;
  wire        time_busy_s;
  wire        clock_running_status;
  wire        sync_status;
  wire        pin_source;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function [31:0] lane_mask;
    input [3:0] sel;
    begin
      lane_mask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
    end
  endfunction

  function adr_hit;
    input [3:0] adr;
    input [3:0] off;
    begin
      adr_hit = (adr == off);
    end
  endfunction

  function [9:0] cal_magnitude;
    input [9:0] cal;
    begin
      if (cal[9]) begin
        cal_magnitude = (~cal) + 10'h001;
      end else begin
        cal_magnitude = cal;
      end
    end
  endfunction

  // ---------------------------------------------------------------
  // wishbone decode
  // ---------------------------------------------------------------
  // one wait state: ack follows the request by one edge and drops after
  // a request held past its ack is taken again, so masters release it
  assign wr_req     = cyc_i & stb_i & we_i & ~ack_o;
  assign rd_req     = cyc_i & stb_i & ~we_i & ~ack_o;
  // unmapped writes miss every decode; they change nothing but drop a half-entered key or a pending arm
  assign hit_ctrl   = adr_hit(adr_i, `RTCCR_OFF_CONTROL);
  assign hit_time   = adr_hit(adr_i, `RTCCR_OFF_TIME);
  assign hit_unlock = adr_hit(adr_i, `RTCCR_OFF_UNLOCK);
  assign wmask      = lane_mask(sel_i);
  assign ctrl_wr    = (dat_i & wmask) | (ctrl_rd & ~wmask);
  assign sec_wr     = wr_req & hit_time & sel_i[1];

  // ---------------------------------------------------------------
  // input synchronisers
  // ---------------------------------------------------------------
  // the pins and the running and busy flags pass two flops; cpu_idle_i and the ticks are used directly
  always @(posedge clk_i) begin
    if (rst_i) begin
      meta_r <= 4'h0;
      sync_r <= 4'h0;
    end else begin
      meta_r <= {time_busy_i, clk_src_running_i, alarm_pulse_i, seconds_clk_i};
      sync_r <= meta_r;
    end
  end

  assign seconds_clk_s = sync_r[0];
  assign alarm_s       = sync_r[1];
  assign clk_running_s = sync_r[2];
  assign time_busy_s   = sync_r[3];

  // ---------------------------------------------------------------
  // status bits
  // ---------------------------------------------------------------
  // running status
  assign clock_running_status = clk_running_s & on_r;
  // sync status
  // pending corrections count as changing, so a read then may be torn
  assign sync_status          = time_busy_s | (cal_count_r != 10'h000);

  // ---------------------------------------------------------------
  // read data
  // ---------------------------------------------------------------
  // reserved zero
  assign ctrl_rd = {6'h00, cal_r, on_r, 1'b0, stop_in_idle_r, 5'h00,
                    pin_source_select_r, clock_running_status, 2'b00,
                    write_unlock_r, sync_status,
                    half_second_status_r, pin_output_enable_r};

  always @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= 32'h0000_0000;
    end else begin
      ack_o <= cyc_i & stb_i & ~ack_o;
      if (rd_req & hit_ctrl) begin
        dat_o <= ctrl_rd;
      end else if (rd_req & hit_time) begin
        dat_o <= {17'h00000, seconds_r, 8'h00};
      end else begin
        // unmapped addresses and the key register read zero
        dat_o <= 32'h0000_0000;
      end
    end
  end

  // ---------------------------------------------------------------
  // unlock sequence
  // ---------------------------------------------------------------
  // key sequence
  // sys_reset_i drops a half-entered key but never the control register
  always @(posedge clk_i) begin
    if (rst_i | sys_reset_i) begin
      unlock_state_r <= UNL_IDLE;
    end else if (wr_req) begin
      case (unlock_state_r)
        UNL_IDLE: begin
          if (hit_unlock & (dat_i == `RTCCR_KEY1)) begin
            unlock_state_r <= UNL_KEY1;
          end
        end
        UNL_KEY1: begin
          if (hit_unlock & (dat_i == `RTCCR_KEY2)) begin
            unlock_state_r <= UNL_ARMED;
          end else begin
            unlock_state_r <= UNL_IDLE;
          end
        end
        UNL_ARMED: begin
          // the arm lasts for exactly one further write
          unlock_state_r <= UNL_IDLE;
        end
        default: begin
          unlock_state_r <= UNL_IDLE;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // control register
  // ---------------------------------------------------------------
  // power-on only; sys_reset_i deliberately not used here
  // byte lanes merge, so a partial write keeps the other fields
  always @(posedge clk_i) begin
    if (rst_i) begin
      cal_r               <= `RTCCR_CAL_RST;
      on_r                <= 1'b0;
      stop_in_idle_r      <= 1'b0;
      pin_source_select_r <= 1'b0;
      write_unlock_r      <= 1'b0;
      pin_output_enable_r <= 1'b0;
    end else if (wr_req & hit_ctrl) begin
      cal_r               <= ctrl_wr[`RTCCR_CAL_HI:`RTCCR_CAL_LO];
      stop_in_idle_r      <= ctrl_wr[`RTCCR_STOP_IN_IDLE_BIT];
      pin_source_select_r <= ctrl_wr[`RTCCR_SEL_BIT];
      pin_output_enable_r <= ctrl_wr[`RTCCR_OE_BIT];
      if (write_unlock_r) begin
        on_r <= ctrl_wr[`RTCCR_ON_BIT];
      end
      if (!ctrl_wr[`RTCCR_WREN_BIT]) begin
        write_unlock_r <= 1'b0;
      end else if (unlock_state_r == UNL_ARMED) begin
        write_unlock_r <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // time register seconds field
  // ---------------------------------------------------------------
  // only the seconds field is kept; the counters take it from seconds_value_o
  always @(posedge clk_i) begin
    if (rst_i) begin
      seconds_r       <= `RTCCR_SEC_RST;
      seconds_write_o <= 1'b0;
      seconds_value_o <= `RTCCR_SEC_RST;
    end else begin
      seconds_write_o <= sec_wr;
      if (sec_wr) begin
        seconds_r       <= dat_i[`RTCCR_SEC_HI:`RTCCR_SEC_LO];
        seconds_value_o <= dat_i[`RTCCR_SEC_HI:`RTCCR_SEC_LO];
      end
    end
  end

  // ---------------------------------------------------------------
  // half-second status
  // ---------------------------------------------------------------
  // the tick toggles the bit; a rising tick beats a same-cycle clear
  always @(posedge clk_i) begin
    if (rst_i) begin
      half_second_status_r <= 1'b0;
    end else if (half_second_tick_i & on_r & ~half_second_status_r) begin
      half_second_status_r <= 1'b1;
    end else if (sec_wr) begin
      half_second_status_r <= 1'b0;
    end else if (half_second_tick_i & on_r) begin
      half_second_status_r <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // drift calibration
  // ---------------------------------------------------------------
  // each minute loads the magnitude; one correction per counter tick
  // a minute tick with corrections still pending restarts the count
  always @(posedge clk_i) begin
    if (rst_i) begin
      cal_count_r        <= 10'h000;
      cal_neg_r          <= 1'b0;
      cal_add_pulse_o    <= 1'b0;
      cal_remove_pulse_o <= 1'b0;
    end else begin
      cal_add_pulse_o    <= 1'b0;
      cal_remove_pulse_o <= 1'b0;
      if (!on_r) begin
        cal_count_r <= 10'h000;
      end else if (minute_tick_i) begin
        cal_count_r <= cal_magnitude(cal_r);
        cal_neg_r   <= cal_r[9];
      end else if (rtc_tick_i & (cal_count_r != 10'h000)) begin
        cal_add_pulse_o    <= ~cal_neg_r;
        cal_remove_pulse_o <= cal_neg_r;
        cal_count_r        <= cal_count_r - 10'h001;
      end
    end
  end

  // ---------------------------------------------------------------
  // enable, idle gating and output pin
  // ---------------------------------------------------------------
  // source select
  assign pin_source = pin_source_select_r ? seconds_clk_s : alarm_s;

  always @(posedge clk_i) begin
    if (rst_i) begin
      module_enable_o  <= 1'b0;
      bus_clk_enable_o <= 1'b1;
      rtc_pin_o        <= 1'b0;
      rtc_pin_oe_o     <= 1'b0;
    end else begin
      module_enable_o  <= on_r;
      // idle gating
      // registered so the gate to the module never glitches mid-cycle
      bus_clk_enable_o <= ~(stop_in_idle_r & cpu_idle_i);
      rtc_pin_oe_o     <= on_r & pin_output_enable_r;
      rtc_pin_o        <= on_r & pin_output_enable_r & pin_source;
    end
  end

endmodule

/* rtccr_ctrl_monitor.sv */
// port-level assertions for the clock control block
`timescale 1ns/100ps
module rtccr_ctrl_monitor (
  input wire clk_i,
  input wire rst_i,
  input wire cyc_i,
  input wire stb_i,
  input wire ack_o,
  input wire cpu_idle_i,
  input wire bus_clk_enable_o,
  input wire module_enable_o,
  input wire rtc_pin_oe_o,
  input wire cal_add_pulse_o,
  input wire cal_remove_pulse_o,
  input wire seconds_write_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // ---------------------------------------------
  // bus handshake
  // ---------------------------------------------
  sequence s_req;
    cyc_i && stb_i && !ack_o;
  endsequence
  sequence s_answer;
    ack_o ##1 !ack_o;
  endsequence
  a_ack_answer: assert property (s_req |=> s_answer)
    else $error("request not answered by a single ack");
  a_ack_cause: assert property (ack_o |-> $past(cyc_i && stb_i))
    else $error("ack without a request");
  // ---------------------------------------------
  // outputs
  // ---------------------------------------------
  a_idle_gate: assert property (!cpu_idle_i |=> bus_clk_enable_o)
    else $error("bus clock gated while cpu busy");
  a_pin_enable: assert property (rtc_pin_oe_o |-> module_enable_o || $past(module_enable_o))
    else $error("pin driven while module disabled");
  a_cal_excl: assert property (!(cal_add_pulse_o && cal_remove_pulse_o))
    else $error("add and remove pulses together");
  a_cal_enable: assert property ((cal_add_pulse_o || cal_remove_pulse_o) |->
    module_enable_o || $past(module_enable_o))
    else $error("calibration pulse while disabled");
  a_sec_pulse: assert property (seconds_write_o |=> !seconds_write_o)
    else $error("seconds write pulse too long");
  a_sec_cause: assert property (seconds_write_o |-> ack_o)
    else $error("seconds write pulse without bus write");
endmodule

/* rtccr_ctrl_tb.sv */
// self-checking bench for the clock control block
`timescale 1ns/100ps
`include "rtccr_map.vh"
module rtccr_ctrl_tb;
  reg clk_i=0, rst_i=1, sys_reset_i=0, cyc_i=0, stb_i=0, we_i=0;
  reg [3:0] adr_i=0, sel_i=0;
  reg [31:0] dat_i=0, rd;
  reg cpu_idle_i=0, minute_tick_i=0, rtc_tick_i=0, half_second_tick_i=0;
  reg seconds_clk_i=0, alarm_pulse_i=0, clk_src_running_i=0, time_busy_i=0;
  reg [9:0] cv;
  wire [31:0] dat_o;
  wire [6:0] seconds_value_o;
  wire ack_o, module_enable_o, bus_clk_enable_o, cal_add_pulse_o, cal_remove_pulse_o;
  wire seconds_write_o, rtc_pin_o, rtc_pin_oe_o;
  integer n_errors=0, n_tests=0, seed=32'h374f, i, j, n, a0, r0, n_add=0, n_rem=0, n_sw=0;
  rtccr_ctrl uut (.clk_i(clk_i), .rst_i(rst_i), .sys_reset_i(sys_reset_i),
    .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
    .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .cpu_idle_i(cpu_idle_i),
    .minute_tick_i(minute_tick_i), .rtc_tick_i(rtc_tick_i),
    .half_second_tick_i(half_second_tick_i), .seconds_clk_i(seconds_clk_i),
    .alarm_pulse_i(alarm_pulse_i), .clk_src_running_i(clk_src_running_i),
    .time_busy_i(time_busy_i), .module_enable_o(module_enable_o),
    .bus_clk_enable_o(bus_clk_enable_o), .cal_add_pulse_o(cal_add_pulse_o),
    .cal_remove_pulse_o(cal_remove_pulse_o), .seconds_write_o(seconds_write_o),
    .seconds_value_o(seconds_value_o), .rtc_pin_o(rtc_pin_o), .rtc_pin_oe_o(rtc_pin_oe_o));
  always #25 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    n_add <= n_add + cal_add_pulse_o;
    n_rem <= n_rem + cal_remove_pulse_o;
    n_sw <= n_sw + seconds_write_o;
  end
  // ---------------------------------------------
  // tasks
  // ---------------------------------------------
  task chk(input [255:0] nm, input [31:0] s, input [31:0] e);
    begin
      n_tests = n_tests + 1;
      if (s !== e) begin
        n_errors = n_errors + 1;
        $display("FAIL %0s exp %h got %h", nm, e, s);
      end
    end
  endtask
  // classic cycle: hold until ack is sampled, then one idle cycle
  task wb(input w, input [3:0] a, input [31:0] d, input [3:0] s);
    integer k;
    begin
      k = 0;
      cyc_i <= 1; stb_i <= 1; we_i <= w; adr_i <= a; dat_i <= d; sel_i <= s;
      @(posedge clk_i);
      while (ack_o !== 1'b1 && k < 20) begin
        @(posedge clk_i);
        k = k + 1;
      end
      if (k == 20) n_errors = n_errors + 1;
      rd = dat_o;
      cyc_i <= 0; stb_i <= 0; we_i <= 0;
      @(posedge clk_i);
    end
  endtask
  task rdc;
    wb(0, `RTCCR_OFF_CONTROL, 0, 4'hf);
  endtask
  task wrc(input [31:0] d);
    wb(1, `RTCCR_OFF_CONTROL, d, 4'hf);
  endtask
  task report_and_stop;
    begin
      $display("tests %0d errors %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
    end
  endtask
  // watchdog: the whole sequence needs well under 20000 cycles
  initial begin
    #(50 * 30000);
    n_errors = n_errors + 1;
    report_and_stop;
  end
  // ---------------------------------------------
  // main sequence
  // ---------------------------------------------
  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 0;
    @(posedge clk_i);
    rdc; chk("ctl_reset", rd, 0);
    wb(0, 4'hc, 0, 4'hf); chk("unmapped", rd, 0);
    wrc(32'hffffffff); rdc; chk("ctl_locked", rd, 32'h03ff2081);
    chk("oe_disabled", rtc_pin_oe_o, 0);
    wb(1, `RTCCR_OFF_UNLOCK, `RTCCR_KEY1, 4'hf);
    wb(1, `RTCCR_OFF_UNLOCK, `RTCCR_KEY2, 4'hf);
    wrc(32'h8008); rdc; chk("unlock_only", rd, 32'h8);
    chk("en_blocked", module_enable_o, 0);
    wrc(32'h8008); rdc; chk("enable", module_enable_o, 1);
    for (i = 0; i < 6; i = i + 1) begin
      n = $random(seed);
      cv = (i == 0) ? 10'h005 : (i == 1) ? 10'h3fb : (i == 2) ? 10'h000 :
           (i == 3) ? 10'h1ff : (i == 4) ? 10'h200 : n[9:0];
      wrc({6'h0, cv, 16'h8008});
      a0 = n_add; r0 = n_rem;
      minute_tick_i <= 1; @(posedge clk_i); minute_tick_i <= 0;
      repeat (600) begin
        rtc_tick_i <= 1; @(posedge clk_i); rtc_tick_i <= 0; @(posedge clk_i);
      end
      chk("cal_add", n_add - a0, cv[9] ? 0 : cv);
      chk("cal_rem", n_rem - r0, cv[9] ? 1024 - cv : 0);
    end
    for (j = 0; j < 2; j = j + 1) begin
      wrc(32'h8009 | (j << 7));
      for (i = 0; i < 8; i = i + 1) begin
        n = $random(seed);
        seconds_clk_i <= n[0]; alarm_pulse_i <= n[1];
        repeat (5) @(posedge clk_i);
        chk("pin", rtc_pin_o, j ? n[0] : n[1]);
        chk("pin_oe", rtc_pin_oe_o, 1);
      end
    end
    wrc(32'h8088); repeat (3) @(posedge clk_i); chk("oe_off", rtc_pin_oe_o, 0);
    clk_src_running_i <= 1; time_busy_i <= 1; repeat (4) @(posedge clk_i);
    rdc; chk("status_on", rd, 32'h80cc);
    clk_src_running_i <= 0; time_busy_i <= 0; repeat (4) @(posedge clk_i);
    rdc; chk("status_off", rd, 32'h8088);
    half_second_tick_i <= 1; @(posedge clk_i); half_second_tick_i <= 0;
    repeat (2) @(posedge clk_i); rdc; chk("half_set", rd[1], 1);
    a0 = n_sw; wb(1, `RTCCR_OFF_TIME, 32'h2a00, 4'h2); @(posedge clk_i);
    chk("sec_value", seconds_value_o, 7'h2a);
    chk("sec_pulse", n_sw - a0, 1);
    rdc; chk("half_clear", rd[1], 0);
    wrc(32'h0008); chk("disable", module_enable_o, 0);
    @(posedge clk_i);
    wrc(32'ha008); cpu_idle_i <= 1; repeat (3) @(posedge clk_i);
    chk("idle_gate", bus_clk_enable_o, 0);
    cpu_idle_i <= 0; repeat (3) @(posedge clk_i); chk("idle_run", bus_clk_enable_o, 1);
    sys_reset_i <= 1; @(posedge clk_i); sys_reset_i <= 0;
    rdc; chk("sys_reset", rd, 32'ha008);
    rst_i <= 1; repeat (2) @(posedge clk_i); rst_i <= 0; @(posedge clk_i);
    rdc; chk("por", rd, 0);
    report_and_stop;
  end
endmodule
bind rtccr_ctrl rtccr_ctrl_monitor u_mon (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
  .stb_i(stb_i), .ack_o(ack_o), .cpu_idle_i(cpu_idle_i), .bus_clk_enable_o(bus_clk_enable_o),
  .module_enable_o(module_enable_o), .rtc_pin_oe_o(rtc_pin_oe_o),
  .cal_add_pulse_o(cal_add_pulse_o), .cal_remove_pulse_o(cal_remove_pulse_o),
  .seconds_write_o(seconds_write_o));

/* rtccr_map.vh */
// register map, field positions, reset values and keys of the clock control block
`ifndef RTCCR_MAP_VH
`define RTCCR_MAP_VH

// ---------------------------------------------------------------
// register byte offsets
// ---------------------------------------------------------------
`define RTCCR_ADDR_W        4
`define RTCCR_OFF_CONTROL   4'h0
`define RTCCR_OFF_TIME      4'h4
`define RTCCR_OFF_UNLOCK    4'h8

// ---------------------------------------------------------------
// control register fields
// ---------------------------------------------------------------
`define RTCCR_CAL_HI        25
`define RTCCR_CAL_LO        16
`define RTCCR_CAL_W         10
`define RTCCR_ON_BIT        15
`define RTCCR_STOP_IN_IDLE_BIT      13
`define RTCCR_SEL_BIT       7
`define RTCCR_CLKON_BIT     6
`define RTCCR_WREN_BIT      3
`define RTCCR_SYNC_BIT      2
`define RTCCR_HALF_BIT      1
`define RTCCR_OE_BIT        0

// ---------------------------------------------------------------
// time register seconds field
// ---------------------------------------------------------------
`define RTCCR_SEC_HI        14
`define RTCCR_SEC_LO        8
`define RTCCR_SEC_W         7

// ---------------------------------------------------------------
// reset values and unlock keys
// ---------------------------------------------------------------
`define RTCCR_CAL_RST       10'h000
`define RTCCR_SEC_RST       7'h00
`define RTCCR_KEY1          32'haa99_6655
`define RTCCR_KEY2          32'h5566_99aa

`endif
